// file: hdl/etsc_pkg.sv
// Shared constants and types for the event time-stamp capture block.
package etsc_pkg;

   localparam int unsigned CLK_HZ       = 100_000_000;
   localparam int unsigned XTAL_HZ      = 32_768;
   // Each tick interval rounds down to whole clock cycles.
   localparam int unsigned TICK_CYCLES  = CLK_HZ / XTAL_HZ;
   localparam int unsigned SEC_TICKS    = XTAL_HZ;

   // Register indices; the bus byte address is four times the index.
   localparam logic [7:0] IDX_SEC       = 8'h00;
   localparam logic [7:0] IDX_MIN       = 8'h01;
   localparam logic [7:0] IDX_HOUR      = 8'h02;
   localparam logic [7:0] IDX_DATE      = 8'h03;
   localparam logic [7:0] IDX_MONTH     = 8'h04;
   localparam logic [7:0] IDX_YEAR      = 8'h05;
   localparam logic [7:0] IDX_DOW       = 8'h06;
   localparam logic [7:0] IDX_STATUS    = 8'h07;
   localparam logic [7:0] IDX_EVCFG     = 8'h09;
   localparam logic [7:0] IDX_CAP_FIRST = 8'h14;
   localparam logic [7:0] IDX_CAP_LAST  = 8'h19;
   localparam logic [7:0] IDX_PTR       = 8'h1A;
   localparam logic [7:0] IDX_STREAM    = 8'h1B;
   localparam logic [7:0] IDX_WRAP      = 8'h00;

   // Status register fields.
   localparam int unsigned ST_EVENT_FLAG  = 0;
   localparam int unsigned ST_HALTED      = 1;
   localparam int unsigned ST_ON_BACKUP   = 2;

   // Event configuration register fields.
   localparam int unsigned CFG_OUT_EN     = 0;
   localparam int unsigned CFG_FILT_LO    = 1;
   localparam int unsigned CFG_SMP_LO     = 3;
   localparam int unsigned CFG_HALT       = 5;
   localparam int unsigned CFG_BKP_DIS    = 6;
   localparam int unsigned CFG_SRC_DIS    = 7;
   localparam logic [7:0]  EVCFG_RESET    = 8'h00;

   // Sampling periods in 32.768 kHz ticks, and filter lengths in samples.
   localparam logic [15:0] SMP_PERIOD_0   = 16'h0001;
   localparam logic [15:0] SMP_PERIOD_1   = 16'h0100;
   localparam logic [15:0] SMP_PERIOD_2   = 16'h1000;
   localparam logic [15:0] SMP_PERIOD_3   = 16'h8000;
   localparam logic [3:0]  FILT_LEN_0     = 4'h1;
   localparam logic [3:0]  FILT_LEN_1     = 4'h2;
   localparam logic [3:0]  FILT_LEN_2     = 4'h4;
   localparam logic [3:0]  FILT_LEN_3     = 4'h8;

   typedef struct packed {
      logic [7:0] dow;
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
   } etsc_time_t;

   localparam etsc_time_t TIME_RESET = '{dow: 8'h00, year: 8'h00, month: 8'h01,
                                         date: 8'h01, hour: 8'h00, min: 8'h00,
                                         sec: 8'h00};

   typedef struct packed {
      logic       write;
      logic [7:0] index;
   } etsc_req_t;

endpackage

// file: hdl/etsc_clock.sv
// BCD time and calendar counters with halt and host load.
`timescale 1ns/1ps
`default_nettype none
module etsc_clock (
   input  wire logic              clk,      // System clock.
   input  wire logic              reset,    // Asynchronous reset, active high.
   input  wire logic              ce,       // Clock enable.
   input  wire logic              tick,     // One 32.768 kHz tick.
   input  wire logic              halt,     // Counters frozen while high.
   input  wire logic              wr_en,    // Host writes one time field.
   input  wire logic [7:0]        wr_idx,   // Field index.
   input  wire logic [7:0]        wr_data,  // Field value.
   output var etsc_pkg::etsc_time_t now     // Live time.
);
   logic [15:0] sub_reg;
   logic        sec_wrap;
   logic [7:0]  last_day;

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction

   always_comb begin
      last_day = 8'h31;
      unique case (now.month)
         8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
         8'h02: last_day = ((now.year[4] == 1'b0 && (now.year[3:0] == 4'h0 ||
                           now.year[3:0] == 4'h4 || now.year[3:0] == 4'h8)) ||
                           (now.year[4] == 1'b1 && (now.year[3:0] == 4'h2 ||
                           now.year[3:0] == 4'h6))) ? 8'h29 : 8'h28;
         default: last_day = 8'h31;
      endcase
   end

   assign sec_wrap = tick && !halt && (sub_reg == 16'(etsc_pkg::SEC_TICKS - 1));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sub_reg <= 16'h0000;
      end else if (ce) begin
         if (wr_en && wr_idx == etsc_pkg::IDX_SEC) begin
            sub_reg <= 16'h0000;
         end else if (tick && !halt) begin
            sub_reg <= sec_wrap ? 16'h0000 : sub_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         now <= etsc_pkg::TIME_RESET;
      end else if (ce) begin
         if (wr_en) begin
            unique case (wr_idx)
               etsc_pkg::IDX_SEC:   now.sec   <= wr_data;
               etsc_pkg::IDX_MIN:   now.min   <= wr_data;
               etsc_pkg::IDX_HOUR:  now.hour  <= wr_data;
               etsc_pkg::IDX_DATE:  now.date  <= wr_data;
               etsc_pkg::IDX_MONTH: now.month <= wr_data;
               etsc_pkg::IDX_YEAR:  now.year  <= wr_data;
               etsc_pkg::IDX_DOW:   now.dow   <= wr_data;
               default: ;
            endcase
         end else if (sec_wrap) begin
            now.sec <= (now.sec == 8'h59) ? 8'h00 : bcd_inc(now.sec);
            if (now.sec == 8'h59) begin
               now.min <= (now.min == 8'h59) ? 8'h00 : bcd_inc(now.min);
               if (now.min == 8'h59) begin
                  now.hour <= (now.hour == 8'h23) ? 8'h00 : bcd_inc(now.hour);
                  if (now.hour == 8'h23) begin
                     now.dow  <= (now.dow == 8'h06) ? 8'h00 : bcd_inc(now.dow);
                     now.date <= (now.date == last_day) ? 8'h01 : bcd_inc(now.date);
                     if (now.date == last_day) begin
                        now.month <= (now.month == 8'h12) ? 8'h01 : bcd_inc(now.month);
                        if (now.month == 8'h12) begin
                           now.year <= (now.year == 8'h99) ? 8'h00 : bcd_inc(now.year);
                        end
                     end
                  end
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: hdl/etsc_sampler.sv
// Periodic sampling, glitch filter and rising-edge detection of the event input.
`timescale 1ns/1ps
`default_nettype none
module etsc_sampler (
   input  wire logic       clk,       // System clock.
   input  wire logic       reset,     // Asynchronous reset, active high.
   input  wire logic       ce,        // Clock enable.
   input  wire logic       tick,      // One 32.768 kHz tick.
   input  wire logic       enable,    // Sampling allowed.
   input  wire logic       level,     // Synchronised event input.
   input  wire logic [1:0] rate_sel,  // Sampling rate code.
   input  wire logic [1:0] filt_sel,  // Glitch filter code.
   output logic            rise       // One-cycle pulse on a filtered rising edge.
);
   logic [15:0] period;
   logic [15:0] cnt_reg;
   logic [3:0]  need;
   logic [3:0]  run_reg;
   logic        state_reg;
   logic        take;

   always_comb begin
      unique case (rate_sel)
         2'h0: period = etsc_pkg::SMP_PERIOD_0;
         2'h1: period = etsc_pkg::SMP_PERIOD_1;
         2'h2: period = etsc_pkg::SMP_PERIOD_2;
         2'h3: period = etsc_pkg::SMP_PERIOD_3;
      endcase
      unique case (filt_sel)
         2'h0: need = etsc_pkg::FILT_LEN_0;
         2'h1: need = etsc_pkg::FILT_LEN_1;
         2'h2: need = etsc_pkg::FILT_LEN_2;
         2'h3: need = etsc_pkg::FILT_LEN_3;
      endcase
   end

   assign take = enable && tick && (cnt_reg >= period - 16'h0001);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_reg <= 16'h0000;
      end else if (ce && tick) begin
         cnt_reg <= take ? 16'h0000 : cnt_reg + 16'h0001;
      end
   end

   // The filter only advances on samples, so it cannot act without sampling.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         run_reg   <= 4'h0;
         state_reg <= 1'b0;
         rise      <= 1'b0;
      end else if (ce) begin
         rise <= 1'b0;
         if (take) begin
            if (level == state_reg) begin
               run_reg <= 4'h0;
            end else if (run_reg + 4'h1 >= need) begin
               run_reg   <= 4'h0;
               state_reg <= level;
               rise      <= level;
            end else begin
               run_reg <= run_reg + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: hdl/etsc_top.sv
// Event time-stamp capture block with its AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
module etsc_top (
   input  wire logic        CLK,                   // System clock, 100 MHz.
   input  wire logic        RESET,                 // Asynchronous reset, active high.
   input  wire logic        CE,                    // Clock enable, freezes state when low.
   input  wire logic        HSEL,                  // AHB slave select.
   input  wire logic [31:0] HADDR,                 // AHB address.
   input  wire logic [1:0]  HTRANS,                // AHB transfer type.
   input  wire logic        HWRITE,                // AHB write.
   input  wire logic [2:0]  HSIZE,                 // AHB size.
   input  wire logic [31:0] HWDATA,                // AHB write data.
   input  wire logic        HREADY,                // AHB bus ready.
   output logic      [31:0] HRDATA,                // AHB read data.
   output logic             HREADYOUT,             // AHB slave ready.
   output logic             HRESP,                 // AHB response, always OKAY.
   input  wire logic        EVENT_INPUT,           // Event switch pin.
   input  wire logic        ON_BACKUP,             // Running from backup supply.
   output logic             EVENT_DETECT_OUT_N,    // Event detect pin, active low.
   output logic             INPUT_SOURCE_DISABLE   // Switches off the input current source.
);
   localparam int unsigned TDIV_W = 12;

   logic [TDIV_W-1:0]    tdiv_reg;
   logic                 tick_reg;
   logic                 evt_meta_reg;
   logic                 evt_sync_reg;
   logic                 bkp_meta_reg;
   logic                 bkp_sync_reg;
   logic                 event_flag_reg;
   logic                 halted_reg;
   logic [7:0]           evcfg_reg;
   logic [7:0]           ptr_reg;
   logic [7:0]           ptr_next;
   etsc_pkg::etsc_time_t cap_reg;
   etsc_pkg::etsc_time_t now;
   etsc_pkg::etsc_req_t  req_reg;
   logic                 req_valid_reg;
   logic                 addr_take;
   logic                 addr_ok;
   logic [7:0]           addr_idx;
   logic                 wr_fire;
   logic [7:0]           wdata;
   logic                 time_write;
   logic                 sample_en;
   logic                 evt_rise;
   logic                 evt_valid;
   logic                 flag_clear;
   logic [7:0]           rd_idx;
   logic [7:0]           rd_byte;

   // Reads the byte at a register index; unmapped and reserved bits read as zero.
   function automatic logic [7:0] reg_read(input logic [7:0] idx,
                                           input etsc_pkg::etsc_time_t t,
                                           input etsc_pkg::etsc_time_t c,
                                           input logic [7:0] st,
                                           input logic [7:0] cfg,
                                           input logic [7:0] ptr);
      reg_read = 8'h00;
      unique case (idx)
         etsc_pkg::IDX_SEC:          reg_read = t.sec;
         etsc_pkg::IDX_MIN:          reg_read = t.min;
         etsc_pkg::IDX_HOUR:         reg_read = t.hour;
         etsc_pkg::IDX_DATE:         reg_read = t.date;
         etsc_pkg::IDX_MONTH:        reg_read = t.month;
         etsc_pkg::IDX_YEAR:         reg_read = t.year;
         etsc_pkg::IDX_DOW:          reg_read = t.dow;
         etsc_pkg::IDX_STATUS:       reg_read = st;
         etsc_pkg::IDX_EVCFG:        reg_read = cfg;
         etsc_pkg::IDX_CAP_FIRST:    reg_read = c.sec;
         etsc_pkg::IDX_CAP_FIRST + 8'h01: reg_read = c.min;
         etsc_pkg::IDX_CAP_FIRST + 8'h02: reg_read = c.hour;
         etsc_pkg::IDX_CAP_FIRST + 8'h03: reg_read = c.date;
         etsc_pkg::IDX_CAP_FIRST + 8'h04: reg_read = c.month;
         etsc_pkg::IDX_CAP_LAST:     reg_read = c.year;
         etsc_pkg::IDX_PTR:          reg_read = ptr;
         default:                    reg_read = 8'h00;
      endcase
   endfunction

   // The 32.768 kHz time base is approximated by dividing the system clock.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         tdiv_reg <= '0;
         tick_reg <= 1'b0;
      end else if (CE) begin
         tick_reg <= (tdiv_reg == TDIV_W'(etsc_pkg::TICK_CYCLES - 1));
         if (tdiv_reg == TDIV_W'(etsc_pkg::TICK_CYCLES - 1)) begin
            tdiv_reg <= '0;
         end else begin
            tdiv_reg <= tdiv_reg + TDIV_W'(1);
         end
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         evt_meta_reg <= 1'b0;
         evt_sync_reg <= 1'b0;
         bkp_meta_reg <= 1'b0;
         bkp_sync_reg <= 1'b0;
      end else if (CE) begin
         evt_meta_reg <= EVENT_INPUT;
         evt_sync_reg <= evt_meta_reg;
         bkp_meta_reg <= ON_BACKUP;
         bkp_sync_reg <= bkp_meta_reg;
      end
   end

   // Sampling stops only on backup with the backup-disable bit set; otherwise it runs on backup too.
   assign sample_en = !(bkp_sync_reg && evcfg_reg[etsc_pkg::CFG_BKP_DIS]);

   etsc_sampler u_sampler (
      .clk      (CLK),
      .reset    (RESET),
      .ce       (CE),
      .tick     (tick_reg),
      .enable   (sample_en),
      .level    (evt_sync_reg),
      .rate_sel (evcfg_reg[etsc_pkg::CFG_SMP_LO +: 2]),
      .filt_sel (evcfg_reg[etsc_pkg::CFG_FILT_LO +: 2]),
      .rise     (evt_rise)
   );

   // Address phase decode.
   assign addr_take = HSEL && HTRANS[1] && HREADY;
   assign addr_ok   = (HADDR[31:10] == 22'h000000) && (HADDR[1:0] == 2'h0);
   assign addr_idx  = HADDR[9:2];

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         req_valid_reg <= 1'b0;
         req_reg       <= '0;
      end else if (CE) begin
         req_valid_reg <= addr_take && addr_ok && HWRITE;
         if (addr_take) begin
            req_reg <= '{write: HWRITE, index: addr_idx};
         end
      end
   end

   assign wr_fire    = CE && req_valid_reg;
   assign wdata      = HWDATA[7:0];
   assign time_write = wr_fire && (req_reg.index <= etsc_pkg::IDX_DOW);

   // A time write releases a halted clock unless a halting event comes in the same cycle.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         halted_reg <= 1'b0;
      end else if (CE) begin
         if (evt_valid && evcfg_reg[etsc_pkg::CFG_HALT]) begin
            halted_reg <= 1'b1;
         end else if (time_write) begin
            halted_reg <= 1'b0;
         end
      end
   end

   etsc_clock u_clock (
      .clk     (CLK),
      .reset   (RESET),
      .ce      (CE),
      .tick    (tick_reg),
      .halt    (halted_reg),
      .wr_en   (time_write),
      .wr_idx  (req_reg.index),
      .wr_data (wdata),
      .now     (now)
   );

   // Only an edge that finds the flag clear counts as a new event.
   assign evt_valid  = evt_rise && !event_flag_reg;
   assign flag_clear = wr_fire && (req_reg.index == etsc_pkg::IDX_STATUS) &&
                       !wdata[etsc_pkg::ST_EVENT_FLAG];

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         event_flag_reg <= 1'b0;
      end else if (CE) begin
         if (evt_valid) begin
            event_flag_reg <= 1'b1;
         end else if (flag_clear) begin
            event_flag_reg <= 1'b0;
         end
      end
   end

   // Captures are only ever loaded by an event; the bus cannot write them.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         cap_reg <= etsc_pkg::TIME_RESET;
      end else if (CE && evt_valid) begin
         cap_reg     <= now;
         cap_reg.dow <= 8'h00;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         evcfg_reg <= etsc_pkg::EVCFG_RESET;
      end else if (CE && wr_fire && req_reg.index == etsc_pkg::IDX_EVCFG) begin
         evcfg_reg <= wdata;
      end
   end

   always_comb begin
      ptr_next = ptr_reg + 8'h01;
      if (ptr_reg >= etsc_pkg::IDX_CAP_LAST) begin
         ptr_next = etsc_pkg::IDX_WRAP;
      end
   end

   // A stream read returns the byte under the pointer and then steps it.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ptr_reg <= etsc_pkg::IDX_WRAP;
      end else if (CE) begin
         if (wr_fire && req_reg.index == etsc_pkg::IDX_PTR) begin
            ptr_reg <= wdata;
         end else if (addr_take && addr_ok && !HWRITE && addr_idx == etsc_pkg::IDX_STREAM) begin
            ptr_reg <= ptr_next;
         end
      end
   end

   assign rd_idx  = (addr_idx == etsc_pkg::IDX_STREAM) ? ptr_reg : addr_idx;
   assign rd_byte = reg_read(rd_idx, now, cap_reg,
                             {5'h00, bkp_sync_reg, halted_reg, event_flag_reg},
                             evcfg_reg, ptr_reg);

   // Read data is prepared in the address phase so the slave never waits.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         HRDATA    <= 32'h00000000;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else if (CE) begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
         if (addr_take && !HWRITE) begin
            HRDATA <= addr_ok ? {24'h000000, rd_byte} : 32'h00000000;
         end
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         EVENT_DETECT_OUT_N   <= 1'b1;
         INPUT_SOURCE_DISABLE <= 1'b0;
      end else if (CE) begin
         EVENT_DETECT_OUT_N   <= !((event_flag_reg || evt_valid) &&
                                   evcfg_reg[etsc_pkg::CFG_OUT_EN]);
         INPUT_SOURCE_DISABLE <= evcfg_reg[etsc_pkg::CFG_SRC_DIS];
      end
   end
endmodule
`default_nettype wire

// file: verif/etsc_assertions.sv
// Port-level assertions for the event time-stamp capture block.
`timescale 1ns/1ps
`default_nettype none
module etsc_checker (
   input wire logic        CLK,                  // Clock.
   input wire logic        RESET,                // Reset.
   input wire logic        CE,                   // Enable.
   input wire logic        HSEL,                 // Select.
   input wire logic [31:0] HADDR,                // Address.
   input wire logic [1:0]  HTRANS,               // Transfer.
   input wire logic        HWRITE,               // Write.
   input wire logic [31:0] HWDATA,               // Write data.
   input wire logic        HREADY,               // Ready in.
   input wire logic [31:0] HRDATA,               // Read data.
   input wire logic        HREADYOUT,            // Ready out.
   input wire logic        HRESP,                // Response.
   input wire logic        EVENT_DETECT_OUT_N,   // Detect pin.
   input wire logic        INPUT_SOURCE_DISABLE  // Source off.
);
   logic        ph_wr_reg;
   logic        ph_rd_reg;
   logic [31:0] ph_addr_reg;
   logic        out_en_reg;
   logic        take;
   assign take = HSEL && HTRANS[1] && HREADY && CE;
   // Shadow of the detect-enable bit, updated in the write data phase.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         {ph_wr_reg, ph_rd_reg, out_en_reg} <= 3'h0;
         ph_addr_reg <= 32'h0;
      end else if (CE) begin
         ph_wr_reg   <= take && HWRITE;
         ph_rd_reg   <= take && !HWRITE;
         ph_addr_reg <= HADDR;
         if (ph_wr_reg && ph_addr_reg == 32'h24) begin
            out_en_reg <= HWDATA[0];
         end
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   property p_ready; HREADYOUT && !HRESP; endproperty
   a_ready: assert property (p_ready) else $error("wait state or error response");
   property p_upper; HRDATA[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("read data upper bits set");
   property p_unmapped; ph_rd_reg && ph_addr_reg[31:10] != 22'h0 |-> HRDATA == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_src_dis;
      ph_wr_reg && CE && ph_addr_reg == 32'h24 |->
         ##2 INPUT_SOURCE_DISABLE == $past(HWDATA[7], 2);
   endproperty
   a_src_dis: assert property (p_src_dis) else $error("source disable not following config");
   property p_out_en; !EVENT_DETECT_OUT_N |-> out_en_reg || $past(out_en_reg); endproperty
   a_out_en: assert property (p_out_en) else $error("detect pin low while disabled");
   property p_freeze; !CE |=> $stable(HRDATA) && $stable(EVENT_DETECT_OUT_N); endproperty
   a_freeze: assert property (p_freeze) else $error("outputs moved while enable low");
   property p_rst; $fell(RESET) |-> EVENT_DETECT_OUT_N && !INPUT_SOURCE_DISABLE; endproperty
   a_rst: assert property (p_rst) else $error("outputs not at reset values");
   property p_rd_hold; !(take && !HWRITE) |=> $stable(HRDATA); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data changed without a read");
endmodule
bind etsc_top etsc_checker u_chk (.CLK, .RESET, .CE, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA,
   .HREADY, .HRDATA, .HREADYOUT, .HRESP, .EVENT_DETECT_OUT_N, .INPUT_SOURCE_DISABLE);
`default_nettype wire

// file: verif/etsc_switch.sv
// Tamper switch model driving the event input, with contact chatter on opening.
`timescale 1ns/1ps
`default_nettype none
module etsc_switch (
   input  wire logic       clk,       // Bench clock.
   input  wire logic       open_cmd,  // High while the enclosure is open.
   input  wire logic [7:0] bounce,    // Chatter cycles after opening.
   output logic            contact    // Event input level.
);
   logic [7:0] chat_reg;
   always_ff @(posedge clk) begin
      if (!open_cmd) begin
         chat_reg <= bounce;
      end else if (chat_reg != 8'h00) begin
         chat_reg <= chat_reg - 8'h01;
      end
   end
   // A real contact chatters before it settles, so the level toggles meanwhile.
   assign contact = open_cmd && (chat_reg == 8'h00 || chat_reg[0]);
endmodule
`default_nettype wire

// file: verif/test_event_timestamp_capture.sv
// Self-checking bench for the event time-stamp capture block.
`timescale 1ns/1ps
`default_nettype none
module test_event_timestamp_capture;
   logic        CLK, RESET, CE, HSEL, HWRITE, HRESP, HREADYOUT, ON_BACKUP, sw_open;
   logic        EVENT_INPUT, EVENT_DETECT_OUT_N, INPUT_SOURCE_DISABLE;
   logic [31:0] HADDR, HWDATA, HRDATA, rdata;
   logic [1:0]  HTRANS;
   logic [7:0]  sw_bounce;
   int          failures, tests_run;
   logic [7:0]  tv [6] = '{8'h12, 8'h34, 8'h11, 8'h22, 8'h03, 8'h24};
   etsc_top dut (.CLK, .RESET, .CE, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
      .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .EVENT_INPUT, .ON_BACKUP,
      .EVENT_DETECT_OUT_N, .INPUT_SOURCE_DISABLE);
   etsc_switch sw (.clk(CLK), .open_cmd(sw_open), .bounce(sw_bounce), .contact(EVENT_INPUT));
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // Bounded wait on an edge for the slave's ready.
   task automatic ready_wait;
      int n;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (HREADYOUT !== 1'b1 && n < 50);
      if (HREADYOUT !== 1'b1) begin
         failures++;
         end_sim();
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge CLK);
      HSEL   <= 1'b1;
      HTRANS <= 2'b10;
      HWRITE <= wr;
      HADDR  <= a;
      ready_wait();
      HSEL   <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= d;
      ready_wait();
      rdata = HRDATA;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, {22'h0, idx, 2'b00}, {24'h0, d});
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
      bus(1'b0, {22'h0, idx, 2'b00}, 32'h0);
      chk(what, rdata, {24'h0, exp});
      chk("response", HRESP, 32'h0);
   endtask
   task automatic wait_det;
      int n;
      n = 0;
      while (EVENT_DETECT_OUT_N !== 1'b0 && n < 12000) begin
         @(posedge CLK);
         n++;
      end
      chk("detect out low", EVENT_DETECT_OUT_N, 32'h0);
      if (EVENT_DETECT_OUT_N !== 1'b0) begin
         end_sim();
      end
   endtask
   // Closing the switch for more than one tick lets the filtered level fall first.
   task automatic reopen(input int low);
      @(posedge CLK);
      sw_open <= 1'b0;
      repeat (low) @(posedge CLK);
      sw_open <= 1'b1;
   endtask
   initial begin
      {RESET, CE, HSEL, HWRITE, ON_BACKUP, sw_open} = 6'b110000;
      HTRANS = 2'b00;
      HADDR = 32'h0;
      HWDATA = 32'h0;
      sw_bounce = 8'h10;
      failures = 0;
      tests_run = 0;
      repeat (5) @(posedge CLK);
      RESET <= 1'b0;
      rd(8'h09, 8'h00, "config reset");
      for (int i = 0; i < 6; i++) wr(8'(i), tv[i]);
      wr(8'h09, 8'h01);
      reopen(10);
      wait_det();
      rd(8'h07, 8'h01, "flag");
      for (int i = 0; i < 6; i++) rd(8'h14 + 8'(i), tv[i], "capture");
      $display("test capture done");
      wr(8'h00, 8'h45);
      reopen(4000);
      repeat (4000) @(posedge CLK);
      rd(8'h14, 8'h12, "first event kept");
      wr(8'h14, 8'h99);
      wr(8'h07, 8'h00);
      rd(8'h14, 8'h12, "capture after clear");
      chk("detect out high", EVENT_DETECT_OUT_N, 32'h1);
      repeat (4000) @(posedge CLK);
      rd(8'h07, 8'h00, "no event on level");
      $display("test series done");
      wr(8'h09, 8'h21);
      reopen(4000);
      wait_det();
      rd(8'h14, 8'h45, "next event capture");
      rd(8'h07, 8'h03, "halted");
      wr(8'h00, 8'h30);
      rd(8'h07, 8'h01, "resumed");
      wr(8'h07, 8'h00);
      reopen(4000);
      wait_det();
      rd(8'h07, 8'h03, "halted again");
      rd(8'h14, 8'h30, "halt capture");
      $display("test halt done");
      wr(8'h00, 8'h50);
      wr(8'h09, 8'h41);
      ON_BACKUP <= 1'b1;
      wr(8'h07, 8'h00);
      reopen(4000);
      repeat (4000) @(posedge CLK);
      rd(8'h07, 8'h04, "backup disabled");
      wr(8'h09, 8'h01);
      reopen(4000);
      wait_det();
      ON_BACKUP <= 1'b0;
      repeat (4) @(posedge CLK);
      rd(8'h07, 8'h01, "flag after backup");
      rd(8'h14, 8'h50, "backup capture");
      $display("test backup done");
      wr(8'h07, 8'h00);
      wr(8'h09, 8'h03);
      reopen(7000);
      repeat (3000) @(posedge CLK);
      sw_open <= 1'b0;
      repeat (7000) @(posedge CLK);
      rd(8'h07, 8'h00, "glitch filtered");
      sw_open <= 1'b1;
      wait_det();
      $display("test filter done");
      wr(8'h09, 8'h80);
      rd(8'h09, 8'h80, "config");
      chk("source disable", INPUT_SOURCE_DISABLE, 32'h1);
      wr(8'h1A, 8'h18);
      rd(8'h1B, 8'h03, "stream month");
      rd(8'h1B, 8'h24, "stream year");
      rd(8'h1B, 8'h50, "stream wrap");
      rd(8'h1A, 8'h01, "pointer");
      bus(1'b0, 32'h400, 32'h0);
      chk("unmapped", rdata, 32'h0);
      @(posedge CLK);
      CE <= 1'b0;
      repeat (3) @(posedge CLK);
      CE <= 1'b1;
      $display("test pointer done");
      end_sim();
   end
endmodule
`default_nettype wire
